// file: fault_rec_regs.svh
// register offsets, field positions, reset values and constants
`ifndef FAULT_REC_REGS_SVH
`define FAULT_REC_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_TRIG_32_39   8'h98
`define OFS_TRIG_40_47   8'h99
`define OFS_TRIG_48_55   8'h9A
`define OFS_TRIG_56_63   8'h9B
`define OFS_HALT_CTRL    8'h9C
`define OFS_SLOT_SEARCH  8'hD9

// ****************************************************************
// fields and reset values
// ****************************************************************
`define HALT_BIT         0
`define SEARCH_BIT       0
`define TRIG_32_39_MASK  8'h07
`define TRIG_RESET       8'h00
`define HALT_RESET       1'b0

// ****************************************************************
// state numbering and recorder region
// ****************************************************************
`define STATE_BASE_32    6'h20
`define STATE_BASE_40    6'h28
`define STATE_BASE_48    6'h30
`define STATE_BASE_56    6'h38
`define SEARCH_BASE      16'hF980

`endif

// file: fault_rec_pkg.sv
// types shared by the fault recorder files
package fault_rec_pkg;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SEARCH = 3'b010,
      ST_WRITE  = 3'b100
   } rec_state_t;

   typedef logic [15:0] nvm_addr_t;

endpackage : fault_rec_pkg

// file: slot_finder.sv
// scanner that walks the recorder region for the first blank slot
`timescale 1ns/1ps
`default_nettype none
`include "fault_rec_regs.svh"

module slot_finder #(
   parameter logic [15:0] RECORD_SIZE = 16'h0020,
   parameter logic [15:0] REGION_LAST = 16'hFFE0
) (
   input  wire logic                 sys_clk_in,
   input  wire logic                 srst_in,
   input  wire logic                 start_in,
   input  wire logic                 probe_done_in,
   input  wire logic                 probe_blank_in,
   output logic                      probe_req_out,
   output fault_rec_pkg::nvm_addr_t  probe_addr_out,
   output logic                      busy_out,
   output logic                      found_out,
   output logic                      full_out
);

   // ****************************************************************
   // probe walk
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         busy_out       <= 1'b0;
         probe_req_out  <= 1'b0;
         probe_addr_out <= `SEARCH_BASE;
         found_out      <= 1'b0;
         full_out       <= 1'b0;
      end else begin
         probe_req_out <= 1'b0;
         found_out     <= 1'b0;
         full_out      <= 1'b0;
         if (start_in && !busy_out) begin
            busy_out       <= 1'b1;
            probe_addr_out <= `SEARCH_BASE;
            probe_req_out  <= 1'b1;
         end else if (busy_out && probe_done_in) begin
            if (probe_blank_in) begin
               busy_out  <= 1'b0;
               found_out <= 1'b1;
            end else if (probe_addr_out >= REGION_LAST) begin
               // no blank slot left: recorder stays idle until a new search finds a blank slot
               busy_out <= 1'b0;
               full_out <= 1'b1;
            end else begin
               probe_addr_out <= probe_addr_out + RECORD_SIZE;
               probe_req_out  <= 1'b1;
            end
         end
      end
   end

endmodule : slot_finder
`default_nettype wire

// file: fault_rec_ctrl.sv
// fault recorder trigger, halt and slot search control
`timescale 1ns/1ps
`default_nettype none
`include "fault_rec_regs.svh"

module fault_rec_ctrl #(
   parameter logic [15:0] RECORD_SIZE = 16'h0020,
   parameter logic [15:0] REGION_LAST = 16'hFFE0
) (
   input  wire logic                 sys_clk_in,
   input  wire logic                 srst_in,
   input  wire logic [7:0]           reg_addr_in,
   input  wire logic [7:0]           reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output logic      [7:0]           reg_rdata_out,
   input  wire logic [5:0]           seq_state_in,
   input  wire logic                 rec_write_done_in,
   output logic                      rec_write_req_out,
   output fault_rec_pkg::nvm_addr_t  rec_addr_out,
   input  wire logic                 probe_done_in,
   input  wire logic                 probe_blank_in,
   output logic                      probe_req_out,
   output fault_rec_pkg::nvm_addr_t  probe_addr_out,
   output logic                      nvm_access_allow_out,
   output logic                      recorder_enabled_out
);

   // ****************************************************************
   // state and registers
   // ****************************************************************
   fault_rec_pkg::rec_state_t state_r;
   fault_rec_pkg::rec_state_t state_nxt;
   logic [7:0] trig_32_r;
   logic [7:0] trig_40_r;
   logic [7:0] trig_48_r;
   logic [7:0] trig_56_r;
   logic       halt_r;
   logic       boot_r;
   logic       search_req_r;
   logic       pending_r;
   logic       slot_ok_r;
   logic [5:0] prev_state_r;
   logic       any_trig;
   logic       active;
   logic       entered_hit;
   logic       start_search;
   logic       launch;
   logic       search_busy;
   logic       found;
   logic       full;
   logic       wr_halt;
   logic       wr_search;

   function automatic logic trig_hit(input logic [5:0] st,
                                     input logic [7:0] m32,
                                     input logic [7:0] m40,
                                     input logic [7:0] m48,
                                     input logic [7:0] m56);
      logic hit;
      hit = 1'b0;
      unique case (st[5:3])
         3'h4:    hit = (st[2:0] < 3'h3) && m32[st[2:0]];
         3'h5:    hit = m40[st[2:0]];
         3'h6:    hit = m48[st[2:0]];
         3'h7:    hit = m56[st[2:0]];
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : trig_hit

   assign any_trig  = |{trig_32_r, trig_40_r, trig_48_r, trig_56_r};
   assign active    = any_trig && !halt_r;
   assign wr_halt   = reg_wr_in && (reg_addr_in == `OFS_HALT_CTRL);
   assign wr_search = reg_wr_in && (reg_addr_in == `OFS_SLOT_SEARCH)
                      && reg_wdata_in[`SEARCH_BIT];
   // entry is a state change, so a held state fires only once
   assign entered_hit = (seq_state_in != prev_state_r)
                        && trig_hit(seq_state_in, trig_32_r, trig_40_r,
                                    trig_48_r, trig_56_r);
   assign start_search = (state_r == fault_rec_pkg::ST_IDLE)
                         && (boot_r || search_req_r);
   assign launch = (state_r == fault_rec_pkg::ST_IDLE) && !start_search
                   && pending_r && active && slot_ok_r;

   slot_finder #(
      .RECORD_SIZE (RECORD_SIZE),
      .REGION_LAST (REGION_LAST)
   ) u_finder (
      .sys_clk_in     (sys_clk_in),
      .srst_in        (srst_in),
      .start_in       (start_search),
      .probe_done_in  (probe_done_in),
      .probe_blank_in (probe_blank_in),
      .probe_req_out  (probe_req_out),
      .probe_addr_out (probe_addr_out),
      .busy_out       (search_busy),
      .found_out      (found),
      .full_out       (full)
   );

   // ****************************************************************
   // software registers
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         trig_32_r <= `TRIG_RESET;
         trig_40_r <= `TRIG_RESET;
         trig_48_r <= `TRIG_RESET;
         trig_56_r <= `TRIG_RESET;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            `OFS_TRIG_32_39: trig_32_r <= reg_wdata_in & `TRIG_32_39_MASK;
            `OFS_TRIG_40_47: trig_40_r <= reg_wdata_in;
            `OFS_TRIG_48_55: trig_48_r <= reg_wdata_in;
            `OFS_TRIG_56_63: trig_56_r <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // a set is refused mid-record so software must read it back
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         halt_r <= `HALT_RESET;
      end else if (wr_halt) begin
         if (!reg_wdata_in[`HALT_BIT]) begin
            halt_r <= 1'b0;
         end else if (state_r != fault_rec_pkg::ST_WRITE) begin
            halt_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `OFS_TRIG_32_39:  reg_rdata_out <= trig_32_r;
            `OFS_TRIG_40_47:  reg_rdata_out <= trig_40_r;
            `OFS_TRIG_48_55:  reg_rdata_out <= trig_48_r;
            `OFS_TRIG_56_63:  reg_rdata_out <= trig_56_r;
            `OFS_HALT_CTRL:   reg_rdata_out <= {7'h00, halt_r};
            `OFS_SLOT_SEARCH: reg_rdata_out <= {7'h00, search_busy
                                                || search_req_r || boot_r};
            default:          reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // trigger capture and search requests
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         prev_state_r <= 6'h00;
         pending_r    <= 1'b0;
      end else begin
         prev_state_r <= seq_state_in;
         // a new entry beats the clear of the one being launched
         if (entered_hit && active) begin
            pending_r <= 1'b1;
         end else if (launch || halt_r) begin
            pending_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         boot_r       <= 1'b1;
         search_req_r <= 1'b0;
      end else begin
         if (start_search) begin
            boot_r <= 1'b0;
         end
         if (wr_search) begin
            search_req_r <= 1'b1;
         end else if (start_search) begin
            search_req_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // sequencing of searches and record writes
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         fault_rec_pkg::ST_IDLE: begin
            if (start_search) begin
               state_nxt = fault_rec_pkg::ST_SEARCH;
            end else if (launch) begin
               state_nxt = fault_rec_pkg::ST_WRITE;
            end
         end
         fault_rec_pkg::ST_SEARCH: begin
            if (found || full) begin
               state_nxt = fault_rec_pkg::ST_IDLE;
            end
         end
         fault_rec_pkg::ST_WRITE: begin
            if (rec_write_done_in) begin
               state_nxt = fault_rec_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_r <= fault_rec_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rec_write_req_out <= 1'b0;
         rec_addr_out      <= `SEARCH_BASE;
         slot_ok_r         <= 1'b0;
      end else begin
         rec_write_req_out <= launch;
         if (found) begin
            rec_addr_out <= probe_addr_out;
            slot_ok_r    <= 1'b1;
         end else if (full) begin
            slot_ok_r <= 1'b0;
         end else if (state_r == fault_rec_pkg::ST_WRITE
                      && rec_write_done_in) begin
            if (rec_addr_out >= REGION_LAST) begin
               slot_ok_r <= 1'b0;
            end else begin
               rec_addr_out <= rec_addr_out + RECORD_SIZE;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         nvm_access_allow_out <= 1'b1;
         recorder_enabled_out <= 1'b0;
      end else begin
         nvm_access_allow_out <= !active;
         recorder_enabled_out <= any_trig;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   property p_write_launch;
      pending_r && active && slot_ok_r && !boot_r && !search_req_r
      && state_r == fault_rec_pkg::ST_IDLE |=> rec_write_req_out
      ##1 state_r == fault_rec_pkg::ST_WRITE;
   endproperty
   a_write_launch: assert property (p_write_launch)
      else $error("pending record was not launched");

   property p_no_untriggered;
      rec_write_req_out |-> $past(pending_r);
   endproperty
   a_no_untriggered: assert property (p_no_untriggered)
      else $error("record written without a trigger");

   property p_enable;
      1 |=> recorder_enabled_out == $past(any_trig);
   endproperty
   a_enable: assert property (p_enable)
      else $error("enable does not follow trigger masks");

   property p_block;
      any_trig && !halt_r |=> !nvm_access_allow_out;
   endproperty
   a_block: assert property (p_block)
      else $error("memory access open while recording");

   property p_halt_open;
      wr_halt && reg_wdata_in[0] && state_r != fault_rec_pkg::ST_WRITE
      |=> halt_r ##1 nvm_access_allow_out;
   endproperty
   a_halt_open: assert property (p_halt_open)
      else $error("halt did not restore memory access");

   property p_halt_refused;
      wr_halt && state_r == fault_rec_pkg::ST_WRITE && !halt_r |=> !halt_r;
   endproperty
   a_halt_refused: assert property (p_halt_refused)
      else $error("halt set during record write");

   property p_search;
      wr_search && state_r == fault_rec_pkg::ST_IDLE && !pending_r
      |-> ##2 probe_req_out && probe_addr_out == `SEARCH_BASE;
   endproperty
   a_search: assert property (p_search)
      else $error("search did not start at region base");

   property p_boot_search;
      $past(srst_in) |-> ##1 probe_req_out;
   endproperty
   a_boot_search: assert property (p_boot_search)
      else $error("no slot search after reset");

   property p_once;
      rec_write_req_out |=> !rec_write_req_out;
   endproperty
   a_once: assert property (p_once)
      else $error("record request repeated");

   property p_halted_quiet;
      halt_r |=> !rec_write_req_out;
   endproperty
   a_halted_quiet: assert property (p_halted_quiet)
      else $error("record written while halted");

   c_record: cover property (rec_write_req_out ##[1:50] rec_write_done_in);
   c_halt_refused: cover property (wr_halt && state_r
                                   == fault_rec_pkg::ST_WRITE);
   c_full: cover property (full);
   c_found: cover property (found);

endmodule : fault_rec_ctrl
`default_nettype wire

// file: nvm_model.sv
// behavioural model of the nonvolatile store behind the recorder
`timescale 1ns/1ps
`default_nettype none
`include "fault_rec_regs.svh"

module nvm_model #(
   parameter logic [15:0] RECORD_SIZE = 16'h0020
) (
   input  wire logic        sys_clk_in,
   input  wire logic        probe_req_in,
   input  wire logic [15:0] probe_addr_in,
   input  wire logic        rec_write_req_in,
   input  wire logic        erase_in,
   input  wire logic [3:0]  lag_in,
   output logic             probe_done_out,
   output logic             probe_blank_out,
   output logic             rec_write_done_out
);
   // slots below used_top hold records, the rest read blank
   logic [15:0] used_top = `SEARCH_BASE;
   logic [15:0] addr;

   // ********************
   // slot probes
   // ********************
   initial begin
      probe_done_out = 1'b0;
      probe_blank_out = 1'b0;
      forever begin
         @(posedge sys_clk_in);
         if (probe_req_in === 1'b1) begin
            addr = probe_addr_in;
            repeat (lag_in) @(posedge sys_clk_in);
            #1;
            probe_done_out = 1'b1;
            probe_blank_out = (addr >= used_top);
            @(posedge sys_clk_in);
            #1;
            probe_done_out = 1'b0;
            // stale result must not look valid after the pulse
            probe_blank_out = ~probe_blank_out;
         end
      end
   end

   // ********************
   // record writes and erase
   // ********************
   initial begin
      rec_write_done_out = 1'b0;
      forever begin
         @(posedge sys_clk_in);
         if (erase_in === 1'b1) begin
            used_top = `SEARCH_BASE;
         end
         if (rec_write_req_in === 1'b1) begin
            repeat (lag_in) @(posedge sys_clk_in);
            #1;
            rec_write_done_out = 1'b1;
            used_top = used_top + RECORD_SIZE;
            @(posedge sys_clk_in);
            #1;
            rec_write_done_out = 1'b0;
         end
      end
   end
endmodule : nvm_model
`default_nettype wire

// file: fault_record_trigger_control_tb.sv
// self-checking bench for the fault recorder trigger control block
`timescale 1ns/1ps
`default_nettype none
`include "fault_rec_regs.svh"

module fault_record_trigger_control_tb;
   logic        sys_clk;
   logic        srst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  rdata;
   logic [5:0]  seq_state;
   logic        wr_done;
   logic        wr_req;
   logic [15:0] rec_addr;
   logic        probe_done;
   logic        probe_blank;
   logic        probe_req;
   logic [15:0] probe_addr;
   logic        allow;
   logic        enabled;
   logic        erase;
   logic [3:0]  lag;
   logic [7:0]  reqs = 8'h00;
   logic [7:0]  v;
   logic [15:0] slot;
   int          n;
   int          failures;
   int          checks;
   logic [7:0]  ofs [5] = '{8'h98, 8'h99, 8'h9A, 8'h9B, 8'h50};
   logic [7:0]  wdat [5] = '{8'hFF, 8'hA5, 8'h5A, 8'hC3, 8'hFF};
   logic [7:0]  xdat [5] = '{8'h07, 8'hA5, 8'h5A, 8'hC3, 8'h00};

   fault_rec_ctrl #(.RECORD_SIZE(16'h0020), .REGION_LAST(16'hFFE0)) dut_u (
      .sys_clk_in(sys_clk),
      .srst_in(srst),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd),
      .reg_rdata_out(rdata),
      .seq_state_in(seq_state),
      .rec_write_done_in(wr_done),
      .rec_write_req_out(wr_req),
      .rec_addr_out(rec_addr),
      .probe_done_in(probe_done),
      .probe_blank_in(probe_blank),
      .probe_req_out(probe_req),
      .probe_addr_out(probe_addr),
      .nvm_access_allow_out(allow),
      .recorder_enabled_out(enabled)
   );

   nvm_model #(.RECORD_SIZE(16'h0020)) nvm_u (
      .sys_clk_in(sys_clk),
      .probe_req_in(probe_req),
      .probe_addr_in(probe_addr),
      .rec_write_req_in(wr_req),
      .erase_in(erase),
      .lag_in(lag),
      .probe_done_out(probe_done),
      .probe_blank_out(probe_blank),
      .rec_write_done_out(wr_done)
   );

   // ********************
   // helpers
   // ********************
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (wr_req === 1'b1) begin
         reqs <= reqs + 8'h01;
      end
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   // leading idle edge keeps strobes from being re-raised in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      d = rdata;
   endtask : rd

   task automatic wait_req(input logic probe);
      for (int i = 0; i < 40; i++) begin
         if ((probe ? probe_req : wr_req) === 1'b1) begin
            return;
         end
         cyc(1);
      end
      $display("MISMATCH t=%0t seen=0 exp=1", $time);
      failures++;
      close_out();
   endtask : wait_req

   // ********************
   // tests
   // ********************
   initial begin
      srst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      seq_state = 6'h00;
      erase = 1'b0;
      lag = 4'h0;
      failures = 0;
      checks = 0;
      n = 0;
      slot = `SEARCH_BASE;
      repeat (3) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      check(16'(allow), 16'h0001);
      check(16'(enabled), 16'h0000);
      wait_req(1'b1);
      check(probe_addr, `SEARCH_BASE);
      cyc(6);
      check(rec_addr, `SEARCH_BASE);
      for (int i = 0; i < 5; i++) begin
         rd(`OFS_TRIG_32_39 + 8'(i), v);
         check(16'(v), 16'h0000);
      end
      $display("test boot done");

      for (int i = 0; i < 5; i++) begin
         wr(ofs[i], wdat[i]);
         rd(ofs[i], v);
         check(16'(v), 16'(xdat[i]));
      end
      check(16'(enabled), 16'h0001);
      check(16'(allow), 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(ofs[i], 8'h00);
      end
      cyc(2);
      check(16'(enabled), 16'h0000);
      check(16'(allow), 16'h0001);
      $display("test register_map done");

      // reserved-state mask is never written
      for (int s = 32; s < 64; s++) begin
         if (s < 35 || s > 39) begin
            wr(`OFS_TRIG_32_39 + 8'(s / 8 - 4), 8'(1 << (s % 8)));
            seq_state = 6'(s ^ 1);
            cyc(12);
            check(16'(reqs), 16'(n));
            check(16'(enabled), 16'h0001);
            seq_state = 6'(s);
            wait_req(1'b0);
            check(rec_addr, slot);
            cyc(12);
            n++;
            slot = slot + 16'h0020;
            check(16'(reqs), 16'(n));
            check(rec_addr, slot);
            wr(`OFS_TRIG_32_39 + 8'(s / 8 - 4), 8'h00);
            seq_state = 6'h00;
         end
      end
      $display("test trigger_sweep done");

      wr(`OFS_TRIG_40_47, 8'h01);
      wr(`OFS_HALT_CTRL, 8'h01);
      rd(`OFS_HALT_CTRL, v);
      check(16'(v), 16'h0001);
      check(16'(allow), 16'h0001);
      seq_state = 6'h28;
      cyc(12);
      check(16'(reqs), 16'(n));
      seq_state = 6'h00;
      wr(`OFS_HALT_CTRL, 8'h00);
      cyc(1);
      check(16'(allow), 16'h0000);
      $display("test halt done");

      lag = 4'h8;
      seq_state = 6'h28;
      wait_req(1'b0);
      cyc(1);
      wr(`OFS_HALT_CTRL, 8'h01);
      rd(`OFS_HALT_CTRL, v);
      check(16'(v), 16'h0000);
      check(16'(allow), 16'h0000);
      // confirm by readback and repeat the write
      for (int k = 0; k < 20 && v !== 8'h01; k++) begin
         wr(`OFS_HALT_CTRL, 8'h01);
         rd(`OFS_HALT_CTRL, v);
      end
      check(16'(v), 16'h0001);
      n++;
      slot = slot + 16'h0020;
      check(16'(reqs), 16'(n));
      check(rec_addr, slot);
      wr(`OFS_HALT_CTRL, 8'h00);
      seq_state = 6'h00;
      $display("test halt_during_write done");

      lag = 4'h6;
      erase = 1'b1;
      cyc(1);
      erase = 1'b0;
      wr(`OFS_SLOT_SEARCH, 8'h01);
      wait_req(1'b1);
      check(probe_addr, `SEARCH_BASE);
      rd(`OFS_SLOT_SEARCH, v);
      check(16'(v), 16'h0001);
      cyc(12);
      check(rec_addr, `SEARCH_BASE);
      rd(`OFS_SLOT_SEARCH, v);
      check(16'(v), 16'h0000);
      lag = 4'h0;
      seq_state = 6'h28;
      wait_req(1'b0);
      check(rec_addr, `SEARCH_BASE);
      cyc(8);
      // first slot now used, so the walk must step over it
      wr(`OFS_SLOT_SEARCH, 8'h01);
      cyc(12);
      check(rec_addr, `SEARCH_BASE + 16'h0020);
      $display("test slot_search done");
      close_out();
   end
endmodule : fault_record_trigger_control_tb
`default_nettype wire
